// File: hw/cpom_pkg.sv
// constants and types for the can probe output monitor
// assumes a single 25 MHz clock and an apb master for software access
//
// How it works
// - one output channel; sensor input and bus output share a ground
// - reproduce classic can to 1 Mbit/s and can fd to 3 Mbit/s
// - transmit only: no frame reception, no arbitration
// - sensor to bus latency about 130 ns typical including sensor
// - pass-through setting forwards detected levels unchanged even when reversed
// - automatic setting swaps high and low paths on reported reversal
// - flag output bus error on bus activity the device did not drive
// - suppress bus error detection while probes are reported reversed
// - led states for self-test failure, no sensor, sensor attached
// - on bus error power steady, status flashes red and green quickly
package cpom_pkg;

	// -----------------------------------------------
	// register map (byte addresses)
	// -----------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_ERRCNT = 12'h008;

	// ctrl fields
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_ERR_EN_BIT = 1;
	localparam int CTRL_ERR_CLR_BIT = 2;
	localparam int CTRL_SELFTEST_FAIL_BIT = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

	// status fields
	localparam int STAT_ERR_BIT = 0;
	localparam int STAT_REV_BIT = 1;
	localparam int STAT_SENSOR_BIT = 2;
	localparam int STAT_TXD_BIT = 3;
	localparam int STAT_RXD_BIT = 4;

	// -----------------------------------------------
	// timing
	// -----------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 40;
	localparam int LATENCY_NS = 130;
	// longest time: round down, at least one cycle
	localparam int LATENCY_CYC = (LATENCY_NS / CLK_NS) < 1 ? 1 : (LATENCY_NS / CLK_NS);
	// slowest bit is 8 us; a foreign edge inside a held bit is an error
	localparam int ERR_SETTLE_NS = 200;
	localparam int ERR_SETTLE_CYC = (ERR_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	// fast status flash 8 Hz half period, power flash 2 Hz half period
	localparam int FAST_FLASH_MS = 62;
	localparam int SLOW_FLASH_MS = 250;
	localparam int FAST_FLASH_CYC = FAST_FLASH_MS * (CLK_HZ / 1000);
	localparam int SLOW_FLASH_CYC = SLOW_FLASH_MS * (CLK_HZ / 1000);

	// -----------------------------------------------
	// led state machine
	// -----------------------------------------------
	typedef enum logic [1:0] {
		CPOM_LED_SELFTEST = 2'b00,
		CPOM_LED_NOSENSOR = 2'b01,
		CPOM_LED_SENSOR = 2'b10,
		CPOM_LED_BUSERR = 2'b11
	} cpom_led_t;

endpackage

// File: hw/cpom_blinker.sv
// square wave generator for led flashing
// assumes clock_i and nrst_i of the parent
`timescale 1ns/100ps
module cpom_blinker #(
	parameter int HALF_CYC = 1000
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	output logic blink_o
);

	localparam int CW = $clog2(HALF_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

	logic [CW-1:0] count;

	initial begin
		if (HALF_CYC < 2) begin
			$error("cpom_blinker: HALF_CYC must be at least 2");
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count <= '0;
			blink_o <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			blink_o <= ~blink_o;
		end else begin
			count <= count + CW'(1);
		end
	end

endmodule

// File: hw/cpom_top.sv
// single-channel can probe output monitor with apb register access
// assumes sensor inputs and bus readback are synchronous to clock_i
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module cpom_top #(
	parameter int FAST_FLASH_CYC = cpom_pkg::FAST_FLASH_CYC,
	parameter int SLOW_FLASH_CYC = cpom_pkg::SLOW_FLASH_CYC,
	parameter int ERR_SETTLE_CYC = cpom_pkg::ERR_SETTLE_CYC
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sensor side
	input wire logic sensor_present_i,
	input wire logic sensor_bit_i,
	input wire logic sensor_reversed_i,
	input wire logic sensor_ok_i,
	input wire logic polarity_pass_through_i,
	// transceiver side
	output logic can_txd_o,
	input wire logic can_rxd_i,
	// indicators
	output logic led_power_o,
	output logic led_red_o,
	output logic led_green_o
);

	// -----------------------------------------------
	// elaboration checks
	// -----------------------------------------------
	initial begin
		if (ERR_SETTLE_CYC < 1 || FAST_FLASH_CYC < 2 || SLOW_FLASH_CYC < 2) begin
			$error("cpom_top: timing parameters out of range");
		end
	end

	// -----------------------------------------------
	// registers
	// -----------------------------------------------
	logic auto_pol;
	logic err_en;
	logic selftest_fail;
	logic bus_err;
	logic [15:0] err_count;
	logic err_clr;

	logic wr_acc;
	logic rd_acc;
	logic addr_ok;
	assign addr_ok = (paddr == cpom_pkg::ADDR_CTRL) || (paddr == cpom_pkg::ADDR_STATUS) ||
		(paddr == cpom_pkg::ADDR_ERRCNT);
	assign wr_acc = psel && penable && pwrite && addr_ok;
	assign rd_acc = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign err_clr = wr_acc && (paddr == cpom_pkg::ADDR_CTRL) &&
		pwdata[cpom_pkg::CTRL_ERR_CLR_BIT];

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			auto_pol <= cpom_pkg::CTRL_RESET[cpom_pkg::CTRL_AUTO_BIT];
			err_en <= cpom_pkg::CTRL_RESET[cpom_pkg::CTRL_ERR_EN_BIT];
			selftest_fail <= cpom_pkg::CTRL_RESET[cpom_pkg::CTRL_SELFTEST_FAIL_BIT];
		end else if (wr_acc && paddr == cpom_pkg::ADDR_CTRL) begin
			auto_pol <= pwdata[cpom_pkg::CTRL_AUTO_BIT];
			err_en <= pwdata[cpom_pkg::CTRL_ERR_EN_BIT];
			selftest_fail <= pwdata[cpom_pkg::CTRL_SELFTEST_FAIL_BIT];
		end
	end

	// -----------------------------------------------
	// polarity correction and output path
	// -----------------------------------------------
	// pass-through pin or software clearing auto both force polarity_pass_through mode
	logic swap_now;
	logic corrected;
	assign swap_now = auto_pol && !polarity_pass_through_i && sensor_reversed_i;
	// swapping high and low lines inverts the differential bit
	assign corrected = swap_now ? ~sensor_bit_i : sensor_bit_i;

	// one register stage: 40 ns of logic delay, within the 130 ns budget
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			can_txd_o <= 1'b1;
		end else if (sensor_present_i && !selftest_fail) begin
			can_txd_o <= corrected;
		end else begin
			can_txd_o <= 1'b1;
		end
	end

	// rxd is read only to watch the bus; nothing is received or arbitrated

	// -----------------------------------------------
	// foreign activity monitor
	// -----------------------------------------------
	// after each driven edge the readback may lag; outside that window
	// rxd must match txd, a dominant we did not drive is foreign
	logic [$clog2(ERR_SETTLE_CYC + 1)-1:0] settle;
	logic txd_prev;
	logic mismatch;
	logic err_set;

	assign mismatch = (can_rxd_i != can_txd_o) && (txd_prev == can_txd_o) &&
		(settle == '0);
	assign err_set = mismatch && err_en && !sensor_reversed_i && sensor_present_i;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			txd_prev <= 1'b1;
			settle <= '0;
		end else begin
			txd_prev <= can_txd_o;
			if (txd_prev != can_txd_o) begin
				settle <= ($bits(settle))'(ERR_SETTLE_CYC);
			end else if (settle != '0) begin
				settle <= settle - ($bits(settle))'(1);
			end
		end
	end

	// set wins over software clear
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_err <= 1'b0;
		end else if (err_set) begin
			bus_err <= 1'b1;
		end else if (err_clr || !sensor_present_i) begin
			bus_err <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			err_count <= '0;
		end else if (err_set && !bus_err && err_count != 16'hffff) begin
			err_count <= err_count + 16'h0001;
		end else if (err_clr) begin
			err_count <= '0;
		end
	end

	// -----------------------------------------------
	// read data
	// -----------------------------------------------
	logic [31:0] next_prdata;
	always_comb begin
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			cpom_pkg::ADDR_CTRL: begin
				next_prdata[cpom_pkg::CTRL_AUTO_BIT] = auto_pol;
				next_prdata[cpom_pkg::CTRL_ERR_EN_BIT] = err_en;
				next_prdata[cpom_pkg::CTRL_SELFTEST_FAIL_BIT] = selftest_fail;
			end
			cpom_pkg::ADDR_STATUS: begin
				next_prdata[cpom_pkg::STAT_ERR_BIT] = bus_err;
				next_prdata[cpom_pkg::STAT_REV_BIT] = sensor_reversed_i;
				next_prdata[cpom_pkg::STAT_SENSOR_BIT] = sensor_present_i;
				next_prdata[cpom_pkg::STAT_TXD_BIT] = can_txd_o;
				next_prdata[cpom_pkg::STAT_RXD_BIT] = can_rxd_i;
			end
			cpom_pkg::ADDR_ERRCNT: begin
				next_prdata[15:0] = err_count;
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	// captured in setup so it is stable through the access phase
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata <= 32'h0000_0000;
		end else if (rd_acc) begin
			prdata <= next_prdata;
		end
	end

	// -----------------------------------------------
	// led control
	// -----------------------------------------------
	logic fast_blink;
	logic slow_blink;

	cpom_blinker #(
		.HALF_CYC(FAST_FLASH_CYC)
	) u_fast (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.blink_o(fast_blink)
	);

	cpom_blinker #(
		.HALF_CYC(SLOW_FLASH_CYC)
	) u_slow (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.blink_o(slow_blink)
	);

	cpom_pkg::cpom_led_t led_state;
	cpom_pkg::cpom_led_t next_led_state;

	always_comb begin
		if (selftest_fail) begin
			next_led_state = cpom_pkg::CPOM_LED_SELFTEST;
		end else if (!sensor_present_i) begin
			next_led_state = cpom_pkg::CPOM_LED_NOSENSOR;
		end else if (bus_err) begin
			next_led_state = cpom_pkg::CPOM_LED_BUSERR;
		end else begin
			next_led_state = cpom_pkg::CPOM_LED_SENSOR;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			led_state <= cpom_pkg::CPOM_LED_NOSENSOR;
		end else begin
			led_state <= next_led_state;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			led_power_o <= 1'b0;
			led_red_o <= 1'b0;
			led_green_o <= 1'b0;
		end else begin
			unique case (led_state)
				cpom_pkg::CPOM_LED_SELFTEST: begin
					led_power_o <= slow_blink;
					led_red_o <= 1'b1;
					led_green_o <= 1'b0;
				end
				cpom_pkg::CPOM_LED_NOSENSOR: begin
					led_power_o <= 1'b1;
					led_red_o <= 1'b0;
					led_green_o <= 1'b0;
				end
				cpom_pkg::CPOM_LED_SENSOR: begin
					led_power_o <= 1'b1;
					led_red_o <= !sensor_ok_i;
					led_green_o <= sensor_ok_i;
				end
				cpom_pkg::CPOM_LED_BUSERR: begin
					led_power_o <= 1'b1;
					led_red_o <= fast_blink;
					led_green_o <= !fast_blink;
				end
			endcase
		end
	end

endmodule

// File: verif/cpom_bus_model.sv
// far-side model: target bus readback seen through the transceiver
// assumes txd_i from cpom_top and foreign_i from the bench
`timescale 1ns/100ps
module cpom_bus_model (
	input wire logic txd_i,
	input wire logic foreign_i,
	output logic rxd_o
);
	// ---------------------------------
	// wired bus
	// ---------------------------------
	// dominant from any node wins
	assign rxd_o = txd_i & ~foreign_i;
endmodule

// File: verif/cpom_checker.sv
// port assertions for the probe output monitor
// assumes a bind to cpom_top and one clock domain
`timescale 1ns/100ps
module cpom_checker (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sensor_present_i,
	input wire logic sensor_bit_i,
	input wire logic polarity_pass_through_i,
	input wire logic can_txd_o,
	input wire logic led_power_o,
	input wire logic led_red_o,
	input wire logic led_green_o
);
	// ---------------------------------
	// properties
	// ---------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	property p_ready; psel |-> pready; endproperty
	property p_slverr;
		psel && penable |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008});
	endproperty
	property p_hold; $past(psel && !penable && !pwrite) == 1'b0 |-> $stable(prdata); endproperty
	property p_idle; !sensor_present_i |=> can_txd_o; endproperty
	property p_pass;
		$past(sensor_present_i && polarity_pass_through_i) && !can_txd_o |-> !$past(sensor_bit_i);
	endproperty
	property p_power; $past(nrst_i, 2) && !led_red_o |-> led_power_o; endproperty
	property p_nosens;
		$past(nrst_i, 2) && !$past(sensor_present_i, 2) && !led_red_o |-> !led_green_o;
	endproperty
	property p_excl; !(led_red_o && led_green_o); endproperty
	a_ready: assert property (p_ready) else $error("pready low in transfer");
	a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
	a_hold: assert property (p_hold) else $error("prdata changed without read");
	a_idle: assert property (p_idle) else $error("txd dominant without sensor");
	a_pass: assert property (p_pass) else $error("txd differs from bit");
	a_power: assert property (p_power) else $error("power led off");
	a_nosens: assert property (p_nosens) else $error("status lit without sensor");
	a_excl: assert property (p_excl) else $error("red and green together");
	c_read: cover property (psel && penable && !pwrite);
	c_unmapped: cover property (psel && penable && pslverr);
	c_flash: cover property (led_green_o ##1 led_red_o);
endmodule

bind cpom_top cpom_checker u_chk (.clock_i(clock_i), .nrst_i(nrst_i), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sensor_present_i(sensor_present_i), .sensor_bit_i(sensor_bit_i),
	.polarity_pass_through_i(polarity_pass_through_i), .can_txd_o(can_txd_o),
	.led_power_o(led_power_o), .led_red_o(led_red_o), .led_green_o(led_green_o));

// File: verif/tb_can_probe_output_monitor.sv
// self-checking bench for the probe output monitor
// assumes cpom_top, cpom_bus_model and the bound checker
`timescale 1ns/100ps
module tb_can_probe_output_monitor;
	logic clock_i, nrst_i, psel, penable, pwrite, pready, pslverr, e;
	logic present, sbit, rev, ok, pass, foreign, txd, rxd, lp, lr, lg;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int fails, tests_run, cyc, n_p, n_r, n_g;
	cpom_top #(.FAST_FLASH_CYC(4), .SLOW_FLASH_CYC(8), .ERR_SETTLE_CYC(5)) u_dut (
		.clock_i(clock_i), .nrst_i(nrst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sensor_present_i(present), .sensor_bit_i(sbit), .sensor_reversed_i(rev),
		.sensor_ok_i(ok), .polarity_pass_through_i(pass), .can_txd_o(txd), .can_rxd_i(rxd),
		.led_power_o(lp), .led_red_o(lr), .led_green_o(lg));
	cpom_bus_model u_bus (.txd_i(txd), .foreign_i(foreign), .rxd_o(rxd));
	// ---------------------------------
	// clock and timeout
	// ---------------------------------
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			report_and_stop();
		end
	end
	// ---------------------------------
	// tasks
	// ---------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk("register", exp, q & m);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic setin(input logic p, b, r, o, s, f);
		@(posedge clock_i);
		present <= p;
		sbit <= b;
		rev <= r;
		ok <= o;
		pass <= s;
		foreign <= f;
	endtask
	task automatic txbit(input logic v, input logic exp);
		@(posedge clock_i);
		sbit <= v;
		tick(1);
		chk("can_txd", {31'h0, exp}, {31'h0, txd});
	endtask
	task automatic flash(input int n);
		n_p = 0;
		n_r = 0;
		n_g = 0;
		repeat (n) begin
			tick(1);
			n_p += lp;
			n_r += lr;
			n_g += lg;
		end
	endtask
	// ---------------------------------
	// sequence
	// ---------------------------------
	initial begin
		{fails, tests_run, cyc} = '0;
		{nrst_i, psel, penable, pwrite, paddr, pwdata} = '0;
		{present, sbit, rev, ok, pass, foreign} = 6'b010100;
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
		rd(12'h000, 32'h3, 32'hf);
		rd(12'h008, 32'h0, 32'hffff);
		rd(12'h00c, 32'h0, 32'hffffffff);
		chk("slverr", 32'h1, {31'h0, e});
		tick(3);
		chk("txd_idle", 32'h1, {31'h0, txd});
		chk("leds", 32'h4, {29'h0, lp, lr, lg});
		setin(1, 1, 0, 1, 1, 0);
		tick(3);
		chk("leds", 32'h5, {29'h0, lp, lr, lg});
		rd(12'h004, 32'h4, 32'h7);
		for (int i = 0; i < 4; i++) txbit(i[0], i[0]);
		setin(1, 1, 1, 1, 1, 0);
		txbit(1'b0, 1'b0);
		rd(12'h004, 32'h6, 32'h7);
		setin(1, 1, 1, 1, 0, 0);
		txbit(1'b0, 1'b1);
		txbit(1'b1, 1'b0);
		apb(1'b1, 12'h000, 32'h2);
		txbit(1'b0, 1'b0);
		apb(1'b1, 12'h000, 32'h3);
		setin(1, 0, 1, 1, 0, 1);
		tick(12);
		rd(12'h004, 32'h0, 32'h1);
		setin(1, 1, 0, 1, 1, 1);
		tick(12);
		rd(12'h004, 32'h1, 32'h1);
		rd(12'h008, 32'h1, 32'hffff);
		setin(1, 1, 0, 1, 1, 0);
		flash(12);
		chk("err_flash", 32'h1, {31'h0, n_p == 12 && n_r > 0 && n_g > 0});
		apb(1'b1, 12'h000, 32'h7);
		rd(12'h004, 32'h0, 32'h1);
		rd(12'h000, 32'h3, 32'hf);
		apb(1'b1, 12'h000, 32'h1);
		setin(1, 1, 0, 1, 1, 1);
		tick(4);
		rd(12'h004, 32'h0, 32'h1);
		rd(12'h008, 32'h0, 32'hffff);
		setin(1, 1, 0, 0, 1, 0);
		tick(3);
		chk("leds", 32'h6, {29'h0, lp, lr, lg});
		apb(1'b1, 12'h000, 32'hb);
		tick(3);
		flash(20);
		chk("selftest", 32'h1, {31'h0, n_r == 20 && n_p > 0 && n_p < 20});
		apb(1'b1, 12'h000, 32'h3);
		setin(0, 0, 0, 1, 1, 0);
		tick(3);
		chk("txd_idle", 32'h1, {31'h0, txd});
		chk("leds", 32'h4, {29'h0, lp, lr, lg});
		report_and_stop();
	end
endmodule
